// ### rtl/cra_pkg.sv
package cra_pkg;
	// byte offsets on the register bus
	localparam logic [7:0] CRA_OFS_RX_ERR = 8'h00;
	localparam logic [7:0] CRA_OFS_TX_ERR = 8'h04;
	localparam logic [7:0] CRA_OFS_OVW = 8'h08;
	localparam logic [7:0] CRA_OFS_MASK_LO = 8'h0C;
	localparam logic [7:0] CRA_OFS_MASK_HI = 8'h10;
	localparam logic [7:0] CRA_OFS_UNREAD_MASK = 8'h14;
	localparam logic [7:0] CRA_OFS_INT_STAT = 8'h18;
	localparam logic [7:0] CRA_OFS_INT_CLR = 8'h1C;
	localparam logic [7:0] CRA_OFS_INT_EN = 8'h20;

	// reset values
	localparam logic [15:0] CRA_OVW_RST = 16'h0000;
	localparam logic [15:0] CRA_MASK_RST = 16'h0000;
	localparam logic CRA_UNREAD_MASK_RST = 1'b1;
	localparam logic [1:0] CRA_INT_RST = 2'h0;
	localparam logic [7:0] CRA_CNT_RST = 8'h00;

	// writable bits of the high mask, 12..10 stay zero
	localparam logic [15:0] CRA_MASK_HI_WMASK = 16'hE3FF;

	// interrupt event positions
	localparam int CRA_EV_OVW = 0;
	localparam int CRA_EV_ACC = 1;

	localparam int CRA_HTRANS_ACTIVE = 1;
	localparam logic [1:0] CRA_HRESP_OKAY = 2'h0;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} cra_aphase_s;

	typedef struct packed {
		logic [15:0] low;
		logic [15:0] high;
	} cra_mask_s;

	// mailbox m sits at bit m+8 for m<8, else m-8
	function automatic logic [3:0] cra_ovw_pos(input logic [3:0] mb);
		return {~mb[3], mb[2:0]};
	endfunction

	// per identifier bit: 1 = left out of the comparison
	function automatic logic [28:0] cra_id_mask(input cra_mask_s m);
		logic [28:0] r;
		r = '0;
		r[7:0] = m.low[15:8];
		r[15:8] = m.low[7:0];
		r[20:18] = m.high[15:13];
		r[17:16] = m.high[9:8];
		r[28:21] = m.high[7:0];
		return r;
	endfunction
endpackage

// ### rtl/cra_top.sv
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - The receive error counter is an 8-bit read-only register showing the protocol engine's count.
// - The transmit error counter is an 8-bit read-only register showing the protocol engine's count.
// - Sixteen overwrite flags, bits 15..8 for mailboxes 7..0 and bits 7..0 for mailboxes 15..8.
// - A flag sets when a message arrives while that mailbox's pending flag is set, clears on write 1, resets to 0.
// - A message arriving for an unread mailbox is still written, replacing the old contents.
// - The local acceptance mask acts only on filtering for mailbox 0.
// - Low mask bits 15..8 drop identifier bits 7..0, bits 7..0 drop identifier bits 15..8.
// - High mask bits 15..13 drop id 20..18, bits 9..8 drop id 17..16, bits 7..0 drop id 28..21.
// - High mask bits 12..10 always read 0 and software writes only 0 there.
// - All mask bits reset to 0 so every identifier bit is compared.
// - The unread request drives the overload line only while its mask bit is 0; the mask resets to 1.
module cra_top
	import cra_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic [1:0] hresp,
	input wire logic [7:0] rx_err_count_in,
	input wire logic [7:0] tx_err_count_in,
	input wire logic rx_store,
	input wire logic [3:0] rx_mbox,
	input wire logic [15:0] receive_pending_flag,
	input wire logic rx_id_valid,
	input wire logic [28:0] rx_id,
	input wire logic [28:0] mb0_id,
	output logic msg_wr_en,
	output logic [3:0] msg_wr_mbox,
	output logic mb0_accept,
	output logic unread_irq_request,
	output logic overload_irq_line,
	output logic irq
);

	cra_aphase_s aph_q, aph_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] rec_q, rec_d, tec_q, tec_d;
	logic [15:0] ovw_q, ovw_d, ovw_set;
	cra_mask_s mask_q, mask_d;
	logic unread_mask_q, unread_mask_d;
	logic [1:0] int_stat_q, int_stat_d, int_en_q, int_en_d, int_ev;
	logic wr_en_q, wr_en_d;
	logic [3:0] wr_mbox_q, wr_mbox_d;
	logic acc_q, acc_d;
	logic ovl_q, ovl_d, ureq_q, ureq_d, irq_q, irq_d;
	logic [28:0] id_mask;
	logic bus_wr;
	logic [15:0] wd16;

	function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] rx_error_count, input logic [7:0] tx_error_count,
			input logic [15:0] ovw, input cra_mask_s m, input logic um, input logic [1:0] st, input logic [1:0] en);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			CRA_OFS_RX_ERR: r = {24'h00_0000, rx_error_count};
			CRA_OFS_TX_ERR: r = {24'h00_0000, tx_error_count};
			CRA_OFS_OVW: r = {16'h0000, ovw};
			CRA_OFS_MASK_LO: r = {16'h0000, m.low};
			CRA_OFS_MASK_HI: r = {16'h0000, m.high & CRA_MASK_HI_WMASK};
			CRA_OFS_UNREAD_MASK: r = {31'h0000_0000, um};
			CRA_OFS_INT_STAT: r = {30'h0000_0000, st};
			CRA_OFS_INT_EN: r = {30'h0000_0000, en};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	function automatic logic aph_take(input logic sel, input logic rdy, input logic [1:0] tr);
		return sel && rdy && tr[CRA_HTRANS_ACTIVE];
	endfunction

	// bus slave: zero wait states, always OKAY
	always_comb begin
		aph_d.valid = aph_take(hsel, hready, htrans);
		aph_d.write = hwrite;
		aph_d.addr = haddr[7:0];
		rdata_d = rdata_q;
		if (aph_take(hsel, hready, htrans) && !hwrite) begin
			rdata_d = rd_mux(haddr[7:0], rec_q, tec_q, ovw_q, mask_q, unread_mask_q, int_stat_q, int_en_q);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_q <= '0;
			rdata_q <= 32'h0000_0000;
		end else begin
			aph_q <= aph_d;
			rdata_q <= rdata_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = CRA_HRESP_OKAY;
	assign hrdata = rdata_q;
	assign bus_wr = aph_q.valid && aph_q.write;
	assign wd16 = hwdata[15:0];

	// overwrite detection per flag bit
	genvar b;
	generate
		for (b = 0; b < 16; b++) begin : g_ovw
			localparam logic [3:0] MB = cra_ovw_pos(4'(b));
			assign ovw_set[b] = rx_store && (rx_mbox == MB) && receive_pending_flag[MB];
		end
	endgenerate

	assign id_mask = cra_id_mask(mask_q);

	always_comb begin
		rec_d = rx_err_count_in;
		tec_d = tx_err_count_in;
		ovw_d = ovw_q & ~((bus_wr && aph_q.addr == CRA_OFS_OVW) ? wd16 : 16'h0000);
		ovw_d = ovw_d | ovw_set;
		mask_d = mask_q;
		unread_mask_d = unread_mask_q;
		int_en_d = int_en_q;
		int_stat_d = int_stat_q;
		if (bus_wr) begin
			unique case (aph_q.addr)
				CRA_OFS_MASK_LO: mask_d.low = wd16;
				CRA_OFS_MASK_HI: mask_d.high = wd16 & CRA_MASK_HI_WMASK;
				CRA_OFS_UNREAD_MASK: unread_mask_d = hwdata[0];
				CRA_OFS_INT_CLR: int_stat_d = int_stat_q & ~hwdata[1:0];
				CRA_OFS_INT_EN: int_en_d = hwdata[1:0];
				default: ;
			endcase
		end
		// mask takes part in mailbox 0 filtering only
		acc_d = rx_id_valid && (((rx_id ^ mb0_id) & ~id_mask) == 29'h0000_0000);
		int_ev = 2'h0;
		int_ev[CRA_EV_OVW] = |ovw_set;
		int_ev[CRA_EV_ACC] = acc_d;
		int_stat_d = int_stat_d | int_ev;
		// old contents are replaced even when unread
		wr_en_d = rx_store;
		wr_mbox_d = rx_mbox;
		ureq_d = |ovw_d;
		ovl_d = ureq_d && !unread_mask_d;
		irq_d = |(int_stat_d & int_en_d);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rec_q <= CRA_CNT_RST;
			tec_q <= CRA_CNT_RST;
			ovw_q <= CRA_OVW_RST;
			mask_q <= {CRA_MASK_RST, CRA_MASK_RST};
			unread_mask_q <= CRA_UNREAD_MASK_RST;
			int_stat_q <= CRA_INT_RST;
			int_en_q <= CRA_INT_RST;
			wr_en_q <= 1'b0;
			wr_mbox_q <= 4'h0;
			acc_q <= 1'b0;
			ureq_q <= 1'b0;
			ovl_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			rec_q <= rec_d;
			tec_q <= tec_d;
			ovw_q <= ovw_d;
			mask_q <= mask_d;
			unread_mask_q <= unread_mask_d;
			int_stat_q <= int_stat_d;
			int_en_q <= int_en_d;
			wr_en_q <= wr_en_d;
			wr_mbox_q <= wr_mbox_d;
			acc_q <= acc_d;
			ureq_q <= ureq_d;
			ovl_q <= ovl_d;
			irq_q <= irq_d;
		end
	end

	assign msg_wr_en = wr_en_q;
	assign msg_wr_mbox = wr_mbox_q;
	assign mb0_accept = acc_q;
	assign unread_irq_request = ureq_q;
	assign overload_irq_line = ovl_q;
	assign irq = irq_q;

	// helper: any mask write seen since reset
	logic mask_wr_seen_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_wr_seen_q <= 1'b0;
		end else if (bus_wr && (aph_q.addr == CRA_OFS_MASK_LO || aph_q.addr == CRA_OFS_MASK_HI)) begin
			mask_wr_seen_q <= 1'b1;
		end
	end

	logic rd_any, rd_rec, rd_tec, rd_mask_hi, rd_unmapped;
	assign rd_any = aph_take(hsel, hready, htrans) && !hwrite;
	assign rd_rec = rd_any && haddr[7:0] == CRA_OFS_RX_ERR;
	assign rd_tec = rd_any && haddr[7:0] == CRA_OFS_TX_ERR;
	assign rd_mask_hi = rd_any && haddr[7:0] == CRA_OFS_MASK_HI;
	assign rd_unmapped = rd_any && (haddr[7:0] > CRA_OFS_INT_EN || haddr[1:0] != 2'h0 || haddr[7:0] == CRA_OFS_INT_CLR);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_rec_read: assert property (rd_rec |=> hrdata == {24'h00_0000, $past(rx_err_count_in, 2)})
		else $error("receive error count read wrong");
	a_tec_read: assert property (rd_tec |=> hrdata == {24'h00_0000, $past(tx_err_count_in, 2)})
		else $error("transmit error count read wrong");
	a_ovw_mb3_map: assert property (rx_store && rx_mbox == 4'h3 && receive_pending_flag[3] |=> ovw_q[11])
		else $error("mailbox 3 overwrite not at bit 11");
	a_ovw_mb12_map: assert property (rx_store && rx_mbox == 4'hC && receive_pending_flag[12] |=> ovw_q[4])
		else $error("mailbox 12 overwrite not at bit 4");
	a_ovw_set_wins: assert property (|ovw_set |=> (ovw_q & $past(ovw_set)) == $past(ovw_set))
		else $error("overwrite flag not set");
	a_ovw_no_set_free: assert property (!rx_store |=> (ovw_q & ~$past(ovw_q)) == 16'h0000)
		else $error("overwrite flag set without arrival");
	a_ovw_w1c: assert property (bus_wr && aph_q.addr == CRA_OFS_OVW && ovw_set == 16'h0000
			|=> (ovw_q & $past(wd16)) == 16'h0000)
		else $error("write one did not clear flag");
	a_msg_replace: assert property (rx_store |=> msg_wr_en && msg_wr_mbox == $past(rx_mbox))
		else $error("arriving message not written");
	a_mb0_filter: assert property (rx_id_valid |=> mb0_accept == $past(((rx_id ^ mb0_id) & ~id_mask) == 29'h0))
		else $error("mailbox 0 filter result wrong");
	a_mask_low_map: assert property (id_mask[7:0] == mask_q.low[15:8] && id_mask[15:8] == mask_q.low[7:0])
		else $error("low mask mapping wrong");
	a_mask_high_map: assert property (id_mask[28:21] == mask_q.high[7:0] && id_mask[20:18] == mask_q.high[15:13]
			&& id_mask[17:16] == mask_q.high[9:8])
		else $error("high mask mapping wrong");
	a_mask_rsvd_zero: assert property (mask_q.high[12:10] == 3'h0)
		else $error("reserved mask bits not zero");
	a_mask_reset_zero: assert property (!mask_wr_seen_q |-> id_mask == 29'h0)
		else $error("mask not clear after reset");
	a_unread_gate: assert property (overload_irq_line == (unread_irq_request && !unread_mask_q))
		else $error("overload line gating wrong");
	a_unread_req: assert property (unread_irq_request == (|ovw_q))
		else $error("unread request does not follow flags");
	a_irq_level: assert property (irq == |(int_stat_q & int_en_q))
		else $error("interrupt output wrong");

	// bus answer and read data, then counter, filter, overwrite, interrupt and mask checks
	a_bus_okay: assert property (hreadyout && hresp == CRA_HRESP_OKAY)
		else $error("bus answer not ready and okay");
	a_rdata_stands: assert property (!rd_any |=> $stable(hrdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (rd_unmapped |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_mask_hi_read: assert property (rd_mask_hi |=> hrdata[12:10] == 3'h0 && hrdata[31:16] == 16'h0000)
		else $error("high mask read shows reserved bits");
	a_rec_follow: assert property ($past(hresetn) |-> rec_q == $past(rx_err_count_in))
		else $error("receive error count not following engine");
	a_tec_follow: assert property ($past(hresetn) |-> tec_q == $past(tx_err_count_in))
		else $error("transmit error count not following engine");
	a_wr_only_rx: assert property (!rx_store |=> !msg_wr_en)
		else $error("message write without arrival");
	a_acc_only_valid: assert property (!rx_id_valid |=> !mb0_accept)
		else $error("accept without identifier");
	a_exact_accept: assert property (rx_id_valid && rx_id == mb0_id |=> mb0_accept)
		else $error("matching identifier refused");
	a_mask_drop_ok: assert property (rx_id_valid && ((rx_id ^ mb0_id) & ~{mask_q.high[7:0], mask_q.high[15:13],
			mask_q.high[9:8], mask_q.low[7:0], mask_q.low[15:8]}) == 29'h0000_0000 |=> mb0_accept)
		else $error("masked identifier bits still compared");
	a_low_compared: assert property (rx_id_valid && mask_q.low[15:8] == 8'h00 && rx_id[7:0] != mb0_id[7:0] |=> !mb0_accept)
		else $error("unmasked low identifier bits ignored");
	a_ovw_stands: assert property (!(bus_wr && aph_q.addr == CRA_OFS_OVW) |=> (ovw_q & $past(ovw_q)) == $past(ovw_q))
		else $error("overwrite flag lost without clear");
	a_ovw_no_pend: assert property (rx_store && !receive_pending_flag[rx_mbox] |=> (ovw_q & ~$past(ovw_q)) == 16'h0000)
		else $error("overwrite flag set with nothing pending");
	a_ovw_mb0_map: assert property (rx_store && rx_mbox == 4'h0 && receive_pending_flag[0] |=> ovw_q[8])
		else $error("mailbox 0 overwrite not at bit 8");
	a_ovw_mb15_map: assert property (rx_store && rx_mbox == 4'hF && receive_pending_flag[15] |=> ovw_q[7])
		else $error("mailbox 15 overwrite not at bit 7");
	a_ovw_ev_stat: assert property (|ovw_set |=> int_stat_q[CRA_EV_OVW])
		else $error("overwrite event not in status");
	a_acc_ev_stat: assert property (acc_d |=> int_stat_q[CRA_EV_ACC])
		else $error("accept event not in status");
	a_int_clr: assert property (bus_wr && aph_q.addr == CRA_OFS_INT_CLR && int_ev == 2'h0 && hwdata[1:0] == 2'h3
			|=> int_stat_q == 2'h0)
		else $error("interrupt status not cleared");
	a_int_stands: assert property (!(bus_wr && aph_q.addr == CRA_OFS_INT_CLR)
			|=> (int_stat_q & $past(int_stat_q)) == $past(int_stat_q))
		else $error("interrupt status lost without clear");
	a_ovl_needs_req: assert property (overload_irq_line |-> unread_irq_request)
		else $error("overload line without unread request");
	a_masked_no_ovl: assert property (unread_mask_q |-> !overload_irq_line)
		else $error("overload line high while masked");
	a_mask_stands: assert property (!bus_wr |=> $stable(mask_q))
		else $error("mask changed without a write");

	c_overwrite: cover property (|ovw_set ##1 |ovw_q);
	c_w1c: cover property (bus_wr && aph_q.addr == CRA_OFS_OVW && |(ovw_q & wd16));
	c_masked_accept: cover property (rx_id_valid && |id_mask && rx_id != mb0_id ##1 mb0_accept);
	c_overload: cover property (!unread_mask_q ##1 overload_irq_line);
	c_unmapped_read: cover property (rd_unmapped ##1 hrdata == 32'h0000_0000);

endmodule

// ### sim/cra_can_node.sv
`timescale 1ns/1ps
module cra_can_node (
	input wire logic hclk,
	output logic rx_store,
	output logic [3:0] rx_mbox,
	output logic rx_id_valid,
	output logic [28:0] rx_id,
	output logic [7:0] rx_err_count_in,
	output logic [7:0] tx_err_count_in
);
	initial begin
		rx_store = 1'b0;
		rx_mbox = 4'h0;
		rx_id_valid = 1'b0;
		rx_id = 29'h0;
		rx_err_count_in = 8'h00;
		tx_err_count_in = 8'h00;
	end
	task automatic set_cnt(input logic [7:0] r, input logic [7:0] t);
		@(posedge hclk);
		rx_err_count_in <= r;
		tx_err_count_in <= t;
	endtask
	// one received frame; released lines show the inverse afterwards
	task automatic send(input logic [3:0] m, input logic [28:0] id);
		@(posedge hclk);
		rx_store <= 1'b1;
		rx_mbox <= m;
		rx_id_valid <= 1'b1;
		rx_id <= id;
		@(posedge hclk);
		rx_store <= 1'b0;
		rx_id_valid <= 1'b0;
		rx_mbox <= ~m;
		rx_id <= ~id;
	endtask
endmodule

// ### sim/cra_top_bench.sv
`timescale 1ns/1ps
module cra_top_bench;
	import cra_pkg::*;
	localparam logic [28:0] ID0 = 29'h0ABC1234;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] pend = 16'h0000;
	logic hreadyout, hwr, acc, urq, ovl, irq, rx_store, rx_id_valid;
	logic [31:0] hrdata;
	logic [1:0] hresp;
	logic [3:0] wmb, rx_mbox;
	logic [28:0] rx_id;
	logic [7:0] rxc, txc;
	int miscompares = 0;
	int samples_checked = 0;
	always #10 hclk = ~hclk;
	cra_can_node node (.hclk(hclk), .rx_store(rx_store), .rx_mbox(rx_mbox), .rx_id_valid(rx_id_valid),
		.rx_id(rx_id), .rx_err_count_in(rxc), .tx_err_count_in(txc));
	cra_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .rx_err_count_in(rxc), .tx_err_count_in(txc),
		.rx_store(rx_store), .rx_mbox(rx_mbox), .receive_pending_flag(pend), .rx_id_valid(rx_id_valid),
		.rx_id(rx_id), .mb0_id(ID0), .msg_wr_en(hwr), .msg_wr_mbox(wmb), .mb0_accept(acc),
		.unread_irq_request(urq), .overload_irq_line(ovl), .irq(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		chk(r, e);
		chk(hresp, CRA_HRESP_OKAY);
	endtask
	task automatic rx(input logic [3:0] m, input logic [28:0] id);
		node.send(m, id);
		#1;
	endtask
	task automatic t_reset;
		rd(CRA_OFS_OVW, 32'h0);
		rd(CRA_OFS_MASK_LO, 32'h0);
		rd(CRA_OFS_MASK_HI, 32'h0);
		rd(CRA_OFS_UNREAD_MASK, 32'h1);
		rd(8'h24, 32'h0);
		rx(4'h0, ID0 ^ 29'h1);
		chk(acc, 1'b0);
	endtask
	task automatic t_counts;
		node.set_cnt(8'hA5, 8'h5A);
		wr(CRA_OFS_RX_ERR, 32'hFF);
		rd(CRA_OFS_RX_ERR, 32'hA5);
		rd(CRA_OFS_TX_ERR, 32'h5A);
	endtask
	task automatic t_mask;
		logic [15:0] lo[5] = '{16'hFF00, 16'h00FF, 16'h0, 16'h0, 16'h0};
		logic [15:0] hi[5] = '{16'h0, 16'h0, 16'hE000, 16'h0300, 16'h00FF};
		logic [28:0] df[5] = '{29'hFF, 29'hFF00, 29'h1C0000, 29'h30000, 29'h1FE00000};
		wr(CRA_OFS_MASK_HI, 32'hE3FF);
		rd(CRA_OFS_MASK_HI, 32'hE3FF);
		for (int i = 0; i < 5; i++) begin
			wr(CRA_OFS_MASK_LO, {16'h0, lo[i]});
			wr(CRA_OFS_MASK_HI, {16'h0, hi[i]});
			rx(4'h0, ID0 ^ df[i]);
			chk(acc, 1'b1);
			rx(4'h0, ID0 ^ {df[i][27:0], df[i][28]});
			chk(acc, 1'b0);
		end
		wr(CRA_OFS_MASK_LO, 32'h0);
		wr(CRA_OFS_MASK_HI, 32'h0);
	endtask
	task automatic t_ovw;
		logic [3:0] mbs[6] = '{4'h0, 4'h3, 4'h7, 4'h8, 4'hC, 4'hF};
		logic [31:0] b;
		wr(CRA_OFS_INT_EN, 32'h1);
		wr(CRA_OFS_UNREAD_MASK, 32'h0);
		foreach (mbs[i]) begin
			b = 32'h1 << (mbs[i] < 4'h8 ? mbs[i] + 8 : mbs[i] - 8);
			pend <= 16'h0;
			rx(mbs[i], ID0);
			chk({hwr, wmb}, {1'b1, mbs[i]});
			rd(CRA_OFS_OVW, 32'h0);
			pend[mbs[i]] <= 1'b1;
			rx(mbs[i], ID0);
			chk({hwr, wmb, urq, ovl, irq}, {1'b1, mbs[i], 3'b111});
			rd(CRA_OFS_OVW, b);
			rd(CRA_OFS_INT_STAT, 32'h3);
			wr(CRA_OFS_OVW, ~b & 32'hFFFF);
			rd(CRA_OFS_OVW, b);
			wr(CRA_OFS_OVW, b);
			wr(CRA_OFS_INT_CLR, 32'h3);
			rd(CRA_OFS_OVW, 32'h0);
			rd(CRA_OFS_INT_STAT, 32'h0);
			chk({urq, irq}, 2'b00);
		end
		wr(CRA_OFS_UNREAD_MASK, 32'h1);
		rx(4'hF, ID0);
		chk({urq, ovl}, 2'b10);
	endtask
	task automatic summarize;
		$display("compares %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100us;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_counts();
		t_mask();
		t_ovw();
		summarize();
	end
endmodule
